// File: shared/ppm_pkg.sv
// package with constants and types for the power path mode control block
package ppm_pkg;
    // ---------------------------------------------------------------
    // mode encodings
    // ---------------------------------------------------------------
    localparam logic [3:0] PPM_MODE_BAT_ONLY = 4'h0;
    localparam logic [3:0] PPM_MODE_BOOST = 4'h8;
    localparam logic [3:0] PPM_MODE_BOOST_OTG = 4'ha;
    localparam logic [3:0] PPM_MODE_NOCHG_BUCK = 4'hc;
    localparam logic [3:0] PPM_MODE_CHG_BUCK = 4'hd;
    localparam logic [3:0] PPM_MODE_WL_OTG = 4'he;
    localparam logic [3:0] PPM_MODE_WL_CHG_OTG = 4'hf;
    // ---------------------------------------------------------------
    // reset values and detail codes
    // ---------------------------------------------------------------
    localparam logic [3:0] PPM_MODE_RESET = 4'h0;
    localparam logic [2:0] PPM_BAT_DTL_OK = 3'h0;
    localparam logic [2:0] PPM_BAT_DTL_OVERCURRENT = 3'h6;
    localparam logic [3:0] PPM_CHG_DTL_OK_MASK = 4'h3;
    // ---------------------------------------------------------------
    // timing in ns and derived cycle counts at 200 MHz
    // ---------------------------------------------------------------
    localparam int PPM_CLOCK_NS = 5;
    localparam int PPM_QUALIFY_TIME_NS = 6000;
    localparam int PPM_ACTIVATION_DELAY_NS = 1000;
    localparam int PPM_QUALIFY_CYCLES = (PPM_QUALIFY_TIME_NS + PPM_CLOCK_NS - 1) / PPM_CLOCK_NS;
    localparam int PPM_ACTIVATION_CYCLES = (PPM_ACTIVATION_DELAY_NS + PPM_CLOCK_NS - 1) / PPM_CLOCK_NS;
    localparam int PPM_SYNC_STAGES = 3;
    // converter direction
    typedef enum logic [1:0] {PPM_CONV_OFF, PPM_CONV_BUCK, PPM_CONV_BOOST, PPM_CONV_STANDBY} ppm_conv_t;
endpackage

// File: shared/ppm_sync_if.sv
// interface carrying raw and filtered pin levels between top and synchroniser
`timescale 1ns/1ps
interface ppm_sync_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] raw; // asynchronous pin levels
    logic [WIDTH-1:0] clean; // qualified levels
    modport filter (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// File: design/ppm_pin_sync.sv
// three-stage synchroniser: a change counts once stages two and three agree
`timescale 1ns/1ps
module ppm_pin_sync
    import ppm_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clock,
    input wire logic rstn,
    ppm_sync_if.filter pins
);
    logic [WIDTH-1:0] stage1; // metastability catcher, read only by stage2
    logic [WIDTH-1:0] stage2; // second stage
    logic [WIDTH-1:0] stage3; // third stage
    logic [WIDTH-1:0] held; // accepted level
    wire [WIDTH-1:0] agree = ~(stage2 ^ stage3); // stages two and three match

    // ---------------------------------------------------------------
    // shift chain and acceptance
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            held <= '0;
        end
        else
        begin
            stage1 <= pins.raw;
            stage2 <= stage1;
            stage3 <= stage2;
            held <= (agree & stage3) | (~agree & held);
        end
    end
    assign pins.clean = held;
endmodule

// File: design/ppm_power_path.sv
// power path mode decode, overcurrent qualification and foldback reporting
// Summary of operation
// - limit battery current while rail under threshold
// - disconnect bit falling counts as power-up
// - hot insertion limit active after delay
// - overcurrent detection only when enabled
// - qualified overcurrent: event, clear good, detail
// - battery only plus disconnect opens switch
// - valid charger input repowers system rail in buck modes
// - adapter buck switching ignores disconnect bit
// - foldback slope handled by analog loop
// - foldback change raises event, updates status
// - charger good from detail field only
// - mode 0x00 battery only, boost standby
// - mode 0x08 battery boost
// - mode 0x0A boost with adapter otg
// - mode 0x0C buck, battery off
// - mode 0x0D buck, battery charging
// - mode 0x0E wireless buck, otg out
// - mode 0x0F wireless buck, otg, charging
// - no source, no battery: all off
// - mode setting is four bits
`timescale 1ns/1ps
module ppm_power_path
    import ppm_pkg::*;
#(
    parameter int QUALIFY_CYCLES = PPM_QUALIFY_CYCLES,
    parameter int ACTIVATION_CYCLES = PPM_ACTIVATION_CYCLES
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] mode_setting,
    input wire logic battery_disconnect_bit,
    input wire logic overcurrent_protect_enable,
    input wire logic [3:0] charger_detail_field,
    input wire logic adapter_valid,
    input wire logic wireless_valid,
    input wire logic battery_present,
    input wire logic rail_below_threshold,
    input wire logic discharge_over_threshold,
    input wire logic foldback_active,
    input wire logic buck_switching,
    output logic adapter_input_switch,
    output logic wireless_input_switch,
    output logic battery_switch,
    output ppm_conv_t converter_mode,
    output logic powerup_current_limit,
    output logic battery_event,
    output logic battery_good_flag,
    output logic [2:0] battery_detail_field,
    output logic charger_event,
    output logic thermal_regulation_status,
    output logic charger_good_flag
);
    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    localparam int NPINS = 7;
    ppm_sync_if #(.WIDTH(NPINS)) pin_bus ();
    assign pin_bus.raw = {adapter_valid, wireless_valid, battery_present, rail_below_threshold,
                          discharge_over_threshold, foldback_active, buck_switching};
    ppm_pin_sync #(.WIDTH(NPINS)) u_sync
    (
        .clock(clock),
        .rstn(rstn),
        .pins(pin_bus.filter)
    );
    wire s_adapter = pin_bus.clean[6]; // adapter valid
    wire s_wireless = pin_bus.clean[5]; // wireless valid
    wire s_battery = pin_bus.clean[4]; // battery present
    wire s_rail_low = pin_bus.clean[3]; // rail below power-up threshold
    wire s_over = pin_bus.clean[2]; // discharge above threshold
    wire s_fold = pin_bus.clean[1]; // foldback loop regulating
    wire s_buck = pin_bus.clean[0]; // buck converter switching

    // counter width helper
    function automatic int cnt_w(input int n);
        return (n < 2) ? 1 : $clog2(n + 1);
    endfunction
    localparam int QW = cnt_w(QUALIFY_CYCLES);
    localparam int AW = cnt_w(ACTIVATION_CYCLES);
    localparam logic [QW-1:0] QUALIFY_LAST = QW'(QUALIFY_CYCLES);
    localparam logic [AW-1:0] ACTIVATE_LAST = AW'(ACTIVATION_CYCLES);

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    logic next_adp; // adapter switch command
    logic next_wl; // wireless switch command
    logic next_bat_mode; // battery switch per mode
    ppm_conv_t next_conv; // converter direction
    wire any_input = s_adapter | s_wireless; // some input valid

    always_comb
    begin
        next_adp = 1'b0;
        next_wl = 1'b0;
        next_bat_mode = 1'b0;
        next_conv = PPM_CONV_OFF;
        case (mode_setting) // four-bit field
            PPM_MODE_BAT_ONLY:
            begin
                next_bat_mode = 1'b1;
                next_conv = PPM_CONV_STANDBY;
            end
            PPM_MODE_BOOST:
            begin
                next_bat_mode = 1'b1;
                next_conv = PPM_CONV_BOOST;
            end
            PPM_MODE_BOOST_OTG:
            begin
                next_adp = 1'b1;
                next_bat_mode = 1'b1;
                next_conv = PPM_CONV_BOOST;
            end
            PPM_MODE_NOCHG_BUCK:
            begin
                next_adp = s_adapter;
                next_wl = s_wireless & ~s_adapter;
                next_conv = any_input ? PPM_CONV_BUCK : PPM_CONV_OFF;
            end
            PPM_MODE_CHG_BUCK:
            begin
                next_adp = s_adapter;
                next_wl = s_wireless & ~s_adapter;
                next_bat_mode = 1'b1;
                next_conv = any_input ? PPM_CONV_BUCK : PPM_CONV_OFF;
            end
            PPM_MODE_WL_OTG:
            begin
                next_wl = s_wireless;
                next_adp = s_wireless;
                next_bat_mode = 1'b1;
                next_conv = s_wireless ? PPM_CONV_BUCK : PPM_CONV_OFF;
            end
            PPM_MODE_WL_CHG_OTG:
            begin
                next_wl = s_wireless;
                next_adp = s_wireless;
                next_bat_mode = 1'b1;
                next_conv = s_wireless ? PPM_CONV_BUCK : PPM_CONV_OFF;
            end
            default:
            begin
                next_bat_mode = 1'b1; // undefined codes fall back to battery feed
                next_conv = PPM_CONV_STANDBY;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // disconnect handling and battery switch
    // ---------------------------------------------------------------
    wire adapter_buck = s_adapter & s_buck; // adapter present and buck running
    wire disconnect_effective = battery_disconnect_bit & ~adapter_buck;
    // disconnected rail is repowered once an input is valid via buck modes
    wire next_bat = s_battery & next_bat_mode & ~disconnect_effective;
    wire no_power = ~s_battery & ~any_input;

    // ---------------------------------------------------------------
    // power-up current limit
    // ---------------------------------------------------------------
    logic battery_seen; // battery present last cycle
    logic disc_seen; // disconnect bit last cycle
    logic [AW-1:0] act_count; // activation delay counter
    wire hot_insert = s_battery & ~battery_seen & ~any_input; // insertion into unpowered device
    wire disc_release = disc_seen & ~battery_disconnect_bit;
    wire act_done = (act_count == ACTIVATE_LAST);
    wire next_limit = next_bat & s_rail_low & act_done;
    logic [AW-1:0] next_act; // next activation count

    always_comb
    begin
        next_act = act_count;
        if (hot_insert)
            next_act = '0; // restart delay after hot insertion
        else if (disc_release)
            next_act = ACTIVATE_LAST; // limit immediate on software release
        else if (!act_done)
            next_act = act_count + AW'(1);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            battery_seen <= 1'b0;
            disc_seen <= 1'b0;
            act_count <= '0;
        end
        else
        begin
            battery_seen <= s_battery;
            disc_seen <= battery_disconnect_bit;
            act_count <= next_act;
        end
    end

    // ---------------------------------------------------------------
    // overcurrent qualification
    // ---------------------------------------------------------------
    logic [QW-1:0] oc_count; // time above threshold
    logic oc_latched; // overcurrent reported
    wire oc_active = overcurrent_protect_enable & s_over & next_bat;
    wire oc_fire = oc_active & (oc_count == QUALIFY_LAST - QW'(1)) & ~oc_latched;
    wire [QW-1:0] next_oc_count = !oc_active ? '0 :
                                  (oc_count == QUALIFY_LAST) ? oc_count : oc_count + QW'(1);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            oc_count <= '0;
            oc_latched <= 1'b0;
        end
        else
        begin
            oc_count <= next_oc_count;
            oc_latched <= oc_fire | (oc_latched & oc_active);
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    logic fold_seen; // foldback state last cycle
    wire fold_change = s_fold ^ fold_seen;
    // foldback slope itself is analog, only its status is reported
    wire next_chg_good = (charger_detail_field <= PPM_CHG_DTL_OK_MASK);
    wire next_oc_flag = oc_fire | oc_latched;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            adapter_input_switch <= 1'b0;
            wireless_input_switch <= 1'b0;
            battery_switch <= 1'b0;
            converter_mode <= PPM_CONV_OFF;
            powerup_current_limit <= 1'b0;
            battery_event <= 1'b0;
            battery_good_flag <= 1'b0;
            battery_detail_field <= PPM_BAT_DTL_OK;
            charger_event <= 1'b0;
            thermal_regulation_status <= 1'b0;
            charger_good_flag <= 1'b0;
            fold_seen <= 1'b0;
        end
        else
        begin
            adapter_input_switch <= next_adp & ~no_power;
            wireless_input_switch <= next_wl & ~no_power;
            battery_switch <= next_bat;
            converter_mode <= no_power ? PPM_CONV_OFF : next_conv;
            powerup_current_limit <= next_limit;
            battery_event <= oc_fire;
            battery_good_flag <= s_battery & ~next_oc_flag;
            battery_detail_field <= next_oc_flag ? PPM_BAT_DTL_OVERCURRENT : PPM_BAT_DTL_OK;
            charger_event <= fold_change;
            thermal_regulation_status <= s_fold;
            charger_good_flag <= next_chg_good;
            fold_seen <= s_fold;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    mode_zero_a: assert property (mode_setting == PPM_MODE_BAT_ONLY && s_battery && !battery_disconnect_bit
        |=> battery_switch && !adapter_input_switch && converter_mode == PPM_CONV_STANDBY)
        else $error("mode 0 decode wrong");
    boost_otg_a: assert property (mode_setting == PPM_MODE_BOOST_OTG && !no_power
        |=> adapter_input_switch && !wireless_input_switch && converter_mode == PPM_CONV_BOOST)
        else $error("otg boost decode wrong");
    nochg_buck_a: assert property (mode_setting == PPM_MODE_NOCHG_BUCK |=> !battery_switch)
        else $error("battery on in no charge buck");
    disc_open_a: assert property (battery_disconnect_bit && !s_adapter |=> !battery_switch)
        else $error("disconnect ignored");
    buck_ignore_a: assert property (adapter_buck && s_battery && next_bat_mode |=> battery_switch)
        else $error("disconnect not ignored under buck");
    oc_enable_a: assert property (!overcurrent_protect_enable |=> !battery_event)
        else $error("overcurrent event while disabled");
    oc_detail_a: assert property (battery_event
        |-> battery_detail_field == PPM_BAT_DTL_OVERCURRENT && !battery_good_flag)
        else $error("overcurrent flags wrong");
    oc_restart_a: assert property (!oc_active |=> oc_count == '0)
        else $error("qualify timer not restarted");
    fold_event_a: assert property ($changed(s_fold)
        |=> charger_event && thermal_regulation_status == $past(s_fold))
        else $error("foldback change missed");
    chg_good_a: assert property ($changed(s_fold) && $stable(charger_detail_field)
        |=> $stable(charger_good_flag))
        else $error("foldback moved charger good");
    limit_a: assert property (next_bat && s_rail_low && act_done |=> powerup_current_limit)
        else $error("power-up limit missing");
    no_power_a: assert property (no_power |=> !battery_switch && converter_mode == PPM_CONV_OFF)
        else $error("rail on with no source");

    oc_cover_c: cover property (battery_event);
    otg_cover_c: cover property (converter_mode == PPM_CONV_BOOST && adapter_input_switch);
    fold_cover_c: cover property (charger_event);
    limit_cover_c: cover property (powerup_current_limit);
endmodule

// File: tb/ppm_power_side.sv
// power-side model: adapter, wireless source, battery and system rail
`timescale 1ns/1ps
module ppm_power_side
    import ppm_pkg::*;
#(
    parameter int RISE = 12
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic adapter_on,
    input wire logic wireless_on,
    input wire logic battery_on,
    input wire logic load_fault,
    input wire logic die_hot,
    input wire logic adapter_input_switch,
    input wire logic wireless_input_switch,
    input wire logic battery_switch,
    input ppm_conv_t converter_mode,
    output logic adapter_valid,
    output logic wireless_valid,
    output logic battery_present,
    output logic rail_below_threshold,
    output logic discharge_over_threshold,
    output logic foldback_active,
    output logic buck_switching
);
    // -----------------------------------------------------------
    // system rail
    // -----------------------------------------------------------
    logic fed; // a closed switch with a live source feeds the rail
    logic [4:0] charge; // cycles the rail has been fed
    assign fed = (battery_switch && battery_on) || (adapter_input_switch && adapter_on)
        || (wireless_input_switch && wireless_on);
    // rail charges its capacitors slowly and collapses at once when unfed
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            charge <= 5'h0;
        else if (!fed)
            charge <= 5'h0;
        else if (charge != 5'(RISE))
            charge <= charge + 5'h1;
    end
    assign rail_below_threshold = (charge != 5'(RISE));
    // -----------------------------------------------------------
    // sources and loads
    // -----------------------------------------------------------
    assign adapter_valid = adapter_on;
    assign wireless_valid = wireless_on;
    assign battery_present = battery_on;
    // fault current only flows through a closed battery switch
    assign discharge_over_threshold = load_fault && battery_on && battery_switch;
    assign foldback_active = die_hot;
    // buck switches only with a live adapter in a buck mode
    assign buck_switching = adapter_on && (converter_mode == PPM_CONV_BUCK);
endmodule

// File: tb/tb.sv
// self-checking bench for the power path mode control block
`timescale 1ns/1ps
`define CHK(g, e) check_val((g), (e))
module tb
    import ppm_pkg::*;
;
    // -----------------------------------------------------------
    // stimulus and wiring
    // -----------------------------------------------------------
    typedef struct {logic [3:0] mode; logic [1:0] src; logic [2:0] sw; ppm_conv_t conv;} ppm_row_t;
    localparam int QUAL = 4;
    localparam int ACT = 2;
    localparam int LIMIT = 5000;
    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic [3:0] mode_setting = 4'h0;
    logic battery_disconnect_bit = 1'h0;
    logic overcurrent_protect_enable = 1'h0;
    logic [3:0] charger_detail_field = 4'h0;
    logic adapter_on = 1'h0, wireless_on = 1'h0, battery_on = 1'h1, load_fault = 1'h0, die_hot = 1'h0;
    logic adapter_valid, wireless_valid, battery_present, rail_below_threshold, discharge_over_threshold;
    logic foldback_active, buck_switching, adapter_input_switch, wireless_input_switch, battery_switch;
    logic powerup_current_limit, battery_event, battery_good_flag, charger_event;
    logic thermal_regulation_status, charger_good_flag;
    logic [2:0] battery_detail_field;
    ppm_conv_t converter_mode;
    int err_total = 0, n_compared = 0, cycles = 0, bev = 0, cev = 0, seen;
    ppm_row_t rows[10];
    ppm_power_path #(.QUALIFY_CYCLES(QUAL), .ACTIVATION_CYCLES(ACT)) dut (.*);
    ppm_power_side side (.*);
    always #2.5 clock = ~clock;
    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic results();
        $display("TB: compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // event pulse counters and hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (battery_event === 1'h1)
            bev++;
        if (charger_event === 1'h1)
            cev++;
        if (cycles == LIMIT)
        begin
            err_total++;
            results();
        end
    end
    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial
    begin
        rows = '{'{4'h0, 2'h0, 3'h1, PPM_CONV_STANDBY}, '{4'h8, 2'h0, 3'h1, PPM_CONV_BOOST},
            '{4'ha, 2'h0, 3'h5, PPM_CONV_BOOST}, '{4'hc, 2'h2, 3'h4, PPM_CONV_BUCK},
            '{4'hc, 2'h1, 3'h2, PPM_CONV_BUCK}, '{4'hd, 2'h2, 3'h5, PPM_CONV_BUCK},
            '{4'hd, 2'h1, 3'h3, PPM_CONV_BUCK}, '{4'he, 2'h1, 3'h7, PPM_CONV_BUCK},
            '{4'hf, 2'h1, 3'h7, PPM_CONV_BUCK}, '{4'h3, 2'h0, 3'h1, PPM_CONV_STANDBY}};
        // outputs stay cleared while reset is held
        settle(3);
        `CHK({converter_mode, battery_switch, battery_event}, 4'h0);
        @(posedge clock);
        rstn <= 1'h1;
        // mode decode table, switches as {adapter, wireless, battery}
        foreach (rows[i])
        begin
            @(posedge clock);
            mode_setting <= rows[i].mode;
            {adapter_on, wireless_on} <= rows[i].src;
            settle(12);
            `CHK({adapter_input_switch, wireless_input_switch, battery_switch}, rows[i].sw);
            `CHK(converter_mode, rows[i].conv);
        end
        // nothing present: all switches open
        @(posedge clock);
        mode_setting <= 4'h0;
        {adapter_on, wireless_on, battery_on} <= 3'h0;
        settle(12);
        `CHK({adapter_input_switch, wireless_input_switch, battery_switch}, 3'h0);
        // battery hot insertion into an unpowered system
        @(posedge clock);
        battery_on <= 1'h1;
        seen = 0;
        repeat (40)
        begin
            settle(1);
            if (powerup_current_limit === 1'h1 && rail_below_threshold)
                seen = 1;
        end
        `CHK(seen, 1);
        `CHK(powerup_current_limit, 1'h0);
        // software disconnect with battery only, then release
        @(posedge clock);
        battery_disconnect_bit <= 1'h1;
        settle(20);
        `CHK({battery_switch, rail_below_threshold}, 2'h1);
        @(posedge clock);
        battery_disconnect_bit <= 1'h0;
        settle(3);
        `CHK({battery_switch, powerup_current_limit}, 2'h3);
        settle(30);
        // disconnected, then a charger arrives and bucks
        @(posedge clock);
        battery_disconnect_bit <= 1'h1;
        settle(20);
        @(posedge clock);
        mode_setting <= 4'hd;
        adapter_on <= 1'h1;
        settle(30);
        `CHK({adapter_input_switch, rail_below_threshold}, 2'h2);
        `CHK(battery_switch, 1'h1);
        @(posedge clock);
        {battery_disconnect_bit, adapter_on, mode_setting} <= 6'h0;
        settle(30);
        // overcurrent ignored while protection is off
        @(posedge clock);
        load_fault <= 1'h1;
        bev = 0;
        settle(30);
        `CHK({bev[3:0], battery_good_flag}, 5'h1);
        // short bursts restart the qualification timer
        @(posedge clock);
        {load_fault, overcurrent_protect_enable} <= 2'h1;
        settle(10);
        bev = 0;
        repeat (4)
        begin
            @(posedge clock);
            load_fault <= 1'h1;
            repeat (2) @(posedge clock);
            load_fault <= 1'h0;
            @(posedge clock);
        end
        settle(10);
        `CHK(bev, 0);
        // sustained overcurrent qualifies once
        @(posedge clock);
        load_fault <= 1'h1;
        settle(QUAL + 12);
        `CHK(bev, 1);
        `CHK({battery_good_flag, battery_detail_field}, {1'h0, PPM_BAT_DTL_OVERCURRENT});
        @(posedge clock);
        load_fault <= 1'h0;
        settle(12);
        `CHK({battery_good_flag, battery_detail_field}, {1'h1, PPM_BAT_DTL_OK});
        // charger good follows the detail field only
        for (int d = 0; d < 16; d++)
        begin
            @(posedge clock);
            charger_detail_field <= 4'(d);
            settle(2);
            `CHK(charger_good_flag, d <= 3);
        end
        // foldback entry and exit each raise one event
        @(posedge clock);
        charger_detail_field <= 4'h3;
        die_hot <= 1'h1;
        cev = 0;
        settle(12);
        `CHK(cev, 1);
        `CHK({thermal_regulation_status, charger_good_flag}, 2'h3);
        @(posedge clock);
        die_hot <= 1'h0;
        settle(12);
        `CHK(cev, 2);
        `CHK({thermal_regulation_status, charger_good_flag}, 2'h1);
        // mid-run reset clears the outputs, then battery feed returns
        @(posedge clock);
        rstn <= 1'h0;
        settle(2);
        `CHK({converter_mode, battery_switch, charger_good_flag, battery_good_flag}, 5'h0);
        @(posedge clock);
        rstn <= 1'h1;
        settle(12);
        `CHK({battery_switch, converter_mode}, {1'h1, PPM_CONV_STANDBY});
        results();
    end
endmodule
